/* hdl/tsx_consts.svh */
// Register offsets, field positions and framing counts of the signaling block
`ifndef TSX_CONSTS_SVH
`define TSX_CONSTS_SVH
`define TSX_RX_SIGNALING_CONTROL 9'h013
`define TSX_AONES 9'h038
`define TSX_RXSIG 9'h040
`define TSX_RX_LATCHED_STATUS_FOUR 9'h093
`define TSX_RSS 9'h098
`define TSX_RX_INTERRUPT_MASK_FOUR 9'h0a3
`define TSX_CSE 9'h0a8
`define TSX_REINS 9'h0c8
`define TSX_SSIE 9'h118
`define TSX_TXSIG 9'h140
`define TSX_HWSEL 9'h1c8
`define TSX_N1 9'h001
`define TSX_N3 9'h003
`define TSX_N4 9'h004
`define TSX_N16 9'h010
`define TSX_B_INTEG 0
`define TSX_B_FRZ_EN 1
`define TSX_B_FRZ_FORCE 2
`define TSX_B_COS 3
`define TSX_INTEG_PREV 2'h2
`define TSX_CNT_MAX 2'h3
`define TSX_T1_POS_LAST 8'hc0
`define TSX_E1_POS_LAST 8'hff
`define TSX_D4_MF_LAST 5'h0b
`define TSX_ESF_MF_LAST 5'h17
`define TSX_E1_MF_LAST 5'h0f
`define TSX_E1_SIG_TS 5'h10
`define TSX_T1_HALF 5'h0c
`define TSX_E1_HALF 5'h10
`define TSX_T1_LAST_BYTE 4'hc
`define TSX_FR_A 5'h05
`define TSX_FR_B 5'h0b
`define TSX_FR_C 5'h11
`define TSX_FR_D 5'h17
`endif

/* hdl/tsx_pkg.sv */
// Types shared by the signaling block
package tsx_pkg;
  typedef logic [3:0] tsx_nib_t;
  typedef struct packed {
    logic hit;
    logic [4:0] ch;
    logic [1:0] sel;
  } tsx_slot_t;
endpackage

/* hdl/tsx_signaling.sv */
// Per-framer signaling insertion and extraction with host register port
// Functional notes
// - Register and pin sources coexist per channel
// - Multiframe boundary copies registers to insert stage
// - Register source only when software enable set
// - ESF carries ABCD; twelve bytes cover 24
// - D4 inserts only A and B
// - E1 uses TS16 in CAS only, not CCS, sixteen bytes
// - E1 timeslots 0 to 31 are channels
// - Pin signaling buffered, inserted into backplane data
// - Pin source only on hardware-selected channels
// - Receive capture on multiframe boundaries, held while freeze active
// - Change latch only for enabled channels
// - Integration needs three stable multiframes
// - Integration setting is global for channels
// - Interrupt low when change latched and unmasked
// - Status records every channel change
// - Receive signaling also serial on pin
// - All-ones forcing only in T1
// - Framer map repeats every 200h
// - Freeze enable holds buffers while an alarm pin is active; force freezes
`timescale 1ns/1ps
`include "tsx_consts.svh"
module tsx_signaling #(
  parameter logic [1:0] FRAMER_ID = 2'h0
) (
  input wire logic mclk,
  input wire logic srst,
  input wire logic [10:0] reg_addr,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [7:0] reg_wdata,
  output logic [7:0] reg_rdata_q,
  output logic interrupt_out_n,
  output logic freeze_active,
  input wire logic mode_e1,
  input wire logic mode_esf,
  input wire logic mode_ccs,
  input wire logic rx_loss_sync,
  input wire logic rx_carrier_loss,
  input wire logic rx_align_change,
  input wire logic tx_backplane_clock,
  input wire logic mf_sync,
  input wire logic tx_backplane_data_in,
  input wire logic tx_signaling_in_pin,
  input wire logic rx_data_in,
  output logic tx_data_out,
  output logic rx_signaling_out_pin
);

  function automatic logic in_grp(input logic [8:0] a, input logic [8:0] b,
                                  input logic [8:0] n);
    return (a >= b) && (a < b + n);
  endfunction

  // Robbed-bit or TS16 position of the current bit
  function automatic tsx_pkg::tsx_slot_t sig_slot(input logic [7:0] pos,
      input logic [4:0] frm, input logic e1, input logic esf,
      input logic ccs);
    tsx_pkg::tsx_slot_t s;
    logic [7:0] p;
    s = '0;
    p = pos - 8'h01;
    if (e1) begin
      if (!ccs && pos[7:3] == `TSX_E1_SIG_TS && frm != 5'h00) begin
        s.hit = 1'b1;
        s.ch = pos[2] ? frm + `TSX_E1_HALF : frm;
        s.sel = pos[1:0];
      end
    end else if (pos != 8'h00 && p[2:0] == 3'h7) begin
      s.ch = p[7:3];
      s.hit = 1'b1;
      if (frm == `TSX_FR_A) s.sel = 2'h0;
      else if (frm == `TSX_FR_B) s.sel = 2'h1;
      else if (esf && frm == `TSX_FR_C) s.sel = 2'h2;
      else if (esf && frm == `TSX_FR_D) s.sel = 2'h3;
      else s.hit = 1'b0;
    end
    return s;
  endfunction

  // Low nibble of each channel byte on the serial signaling pins
  function automatic tsx_pkg::tsx_slot_t nib_slot(input logic [7:0] pos,
                                                  input logic e1);
    tsx_pkg::tsx_slot_t s;
    logic [7:0] p;
    p = e1 ? pos : pos - 8'h01;
    s.hit = p[2] && (e1 || pos != 8'h00);
    s.ch = p[7:3];
    s.sel = p[1:0];
    return s;
  endfunction

  // ---------------- Host side ----------------
  logic fr_hit, wr_hit;
  logic [8:0] off;
  logic [4:0] gsel;
  logic [2:0] rx_signaling_control_q;
  logic rx_latched_status_four_q, rx_interrupt_mask_four_q, freeze_q;
  logic [31:0] cse_q, reins_q, ssie_q, hwsel_q, aones_q, rss_q;
  logic [31:0] rss_clr, chg;
  logic [7:0] tx_sig_q [16];
  logic [127:0] rxv_v, swv_v;
  logic [7:0] rd_val, rx_byte;
  logic [4:0] rb_hi, rb_lo;
  logic [2:0] los_m_q, los_q;
  logic tog_m_q, tog_s_q, tog_d_q, mf_ev, ack_tog_q, mf_tog_q;
  logic [127:0] snap_val_q, rx_done_v;
  logic [31:0] snap_sw_q, snap_hw_q, snap_ao_q;

  assign fr_hit = reg_addr[10:9] == FRAMER_ID;
  assign off = reg_addr[8:0];
  assign wr_hit = reg_wr && fr_hit;
  assign gsel = {off[1:0], 3'h0};

  always_ff @(posedge mclk) begin
    if (srst) begin
      rx_signaling_control_q <= 3'h0;
      rx_interrupt_mask_four_q <= 1'b0;
      cse_q <= 32'h0;
      reins_q <= 32'h0;
      ssie_q <= 32'h0;
      hwsel_q <= 32'h0;
      aones_q <= 32'h0;
    end else if (wr_hit) begin
      if (in_grp(off, `TSX_RX_SIGNALING_CONTROL, `TSX_N1)) rx_signaling_control_q <= reg_wdata[2:0];
      if (in_grp(off, `TSX_RX_INTERRUPT_MASK_FOUR, `TSX_N1)) rx_interrupt_mask_four_q <= reg_wdata[`TSX_B_COS];
      if (in_grp(off, `TSX_CSE, `TSX_N4)) cse_q[gsel +: 8] <= reg_wdata;
      if (in_grp(off, `TSX_REINS, `TSX_N4)) reins_q[gsel +: 8] <= reg_wdata;
      if (in_grp(off, `TSX_SSIE, `TSX_N4)) ssie_q[gsel +: 8] <= reg_wdata;
      if (in_grp(off, `TSX_HWSEL, `TSX_N4)) hwsel_q[gsel +: 8] <= reg_wdata;
      if (in_grp(off, `TSX_AONES, `TSX_N3)) aones_q[gsel +: 8] <= reg_wdata;
    end
  end

  always_ff @(posedge mclk) begin
    if (srst) begin
      for (int i = 0; i < 16; i++) tx_sig_q[i] <= 8'h00;
    end else if (wr_hit && in_grp(off, `TSX_TXSIG, `TSX_N16)) begin
      tx_sig_q[off[3:0]] <= reg_wdata;
    end
  end

  // Byte k: high nibble channel k, low nibble channel k plus half
  always_comb begin
    rb_hi = {1'b0, off[3:0]};
    rb_lo = rb_hi + (mode_e1 ? `TSX_E1_HALF : `TSX_T1_HALF);
    rx_byte = {rxv_v[{rb_hi, 2'h0} +: 4], rxv_v[{rb_lo, 2'h0} +: 4]};
    if (!mode_e1 && off[3:0] >= `TSX_T1_LAST_BYTE) rx_byte = 8'h00;
  end

  always_comb begin
    rd_val = 8'h00;
    if (in_grp(off, `TSX_RX_SIGNALING_CONTROL, `TSX_N1)) rd_val = {5'h00, rx_signaling_control_q};
    else if (in_grp(off, `TSX_AONES, `TSX_N3)) rd_val = aones_q[gsel +: 8];
    else if (in_grp(off, `TSX_RXSIG, `TSX_N16)) rd_val = rx_byte;
    else if (in_grp(off, `TSX_RX_LATCHED_STATUS_FOUR, `TSX_N1)) rd_val = {4'h0, rx_latched_status_four_q, 3'h0};
    else if (in_grp(off, `TSX_RSS, `TSX_N4)) rd_val = rss_q[gsel +: 8];
    else if (in_grp(off, `TSX_RX_INTERRUPT_MASK_FOUR, `TSX_N1)) rd_val = {4'h0, rx_interrupt_mask_four_q, 3'h0};
    else if (in_grp(off, `TSX_CSE, `TSX_N4)) rd_val = cse_q[gsel +: 8];
    else if (in_grp(off, `TSX_REINS, `TSX_N4)) rd_val = reins_q[gsel +: 8];
    else if (in_grp(off, `TSX_SSIE, `TSX_N4)) rd_val = ssie_q[gsel +: 8];
    else if (in_grp(off, `TSX_TXSIG, `TSX_N16)) rd_val = tx_sig_q[off[3:0]];
    else if (in_grp(off, `TSX_HWSEL, `TSX_N4)) rd_val = hwsel_q[gsel +: 8];
  end

  always_ff @(posedge mclk) begin
    if (srst) reg_rdata_q <= 8'h00;
    else if (reg_rd) reg_rdata_q <= fr_hit ? rd_val : 8'h00;
  end

  // Alarm pins cross in; freeze computed here and sent to the link
  always_ff @(posedge mclk) begin
    if (srst) begin
      los_m_q <= 3'h0;
      los_q <= 3'h0;
      freeze_q <= 1'b0;
    end else begin
      los_m_q <= {rx_align_change, rx_carrier_loss, rx_loss_sync};
      los_q <= los_m_q;
      freeze_q <= (rx_signaling_control_q[`TSX_B_FRZ_EN] && |los_q) ||
                  rx_signaling_control_q[`TSX_B_FRZ_FORCE];
    end
  end
  assign freeze_active = freeze_q;

  // Multiframe toggle from the link; one event per boundary
  always_ff @(posedge mclk) begin
    if (srst) begin
      tog_m_q <= 1'b0;
      tog_s_q <= 1'b0;
      tog_d_q <= 1'b0;
    end else begin
      tog_m_q <= mf_tog_q;
      tog_s_q <= tog_m_q;
      tog_d_q <= tog_s_q;
    end
  end
  assign mf_ev = tog_s_q ^ tog_d_q;

  for (genvar c = 0; c < 32; c++) begin : g_snap
    if (c < 12) begin : g_a
      assign swv_v[c*4 +: 4] = tx_sig_q[c][7:4];
    end else if (c < 16) begin : g_b
      assign swv_v[c*4 +: 4] = mode_e1 ? tx_sig_q[c][7:4] :
                               tx_sig_q[c-12][3:0];
    end else if (c < 24) begin : g_c
      assign swv_v[c*4 +: 4] = mode_e1 ? tx_sig_q[c-16][3:0] :
                               tx_sig_q[c-12][3:0];
    end else begin : g_d
      assign swv_v[c*4 +: 4] = mode_e1 ? tx_sig_q[c-16][3:0] : 4'h0;
    end
  end

  // Snapshot stays stable until the next boundary, so the link may copy it
  always_ff @(posedge mclk) begin
    if (srst) begin
      snap_val_q <= 128'h0;
      snap_sw_q <= 32'h0;
      snap_hw_q <= 32'h0;
      snap_ao_q <= 32'h0;
      ack_tog_q <= 1'b0;
    end else if (mf_ev) begin
      snap_val_q <= swv_v;
      snap_sw_q <= ssie_q;
      snap_hw_q <= hwsel_q;
      snap_ao_q <= mode_e1 ? 32'h0 : aones_q;
      ack_tog_q <= ~ack_tog_q;
    end
  end

  // Per-channel capture, change detection and integration
  for (genvar c = 0; c < 32; c++) begin : g_ch
    tsx_pkg::tsx_nib_t smp, rxv_q, rep_q, cand_q;
    logic [1:0] cnt_q;
    logic upd;
    assign smp = rx_done_v[c*4 +: 4];
    assign upd = mf_ev && !freeze_q;
    assign rxv_v[c*4 +: 4] = rxv_q;
    assign chg[c] = upd && smp != rep_q && (!rx_signaling_control_q[`TSX_B_INTEG] ||
        (smp == cand_q && cnt_q >= `TSX_INTEG_PREV));
    always_ff @(posedge mclk) begin
      if (srst) begin
        rxv_q <= 4'h0;
        rep_q <= 4'h0;
        cand_q <= 4'h0;
        cnt_q <= 2'h0;
      end else if (upd) begin
        rxv_q <= smp;
        if (chg[c]) rep_q <= smp;
        if (smp != cand_q) begin
          cand_q <= smp;
          cnt_q <= 2'h1;
        end else if (cnt_q != `TSX_CNT_MAX) begin
          cnt_q <= cnt_q + 2'h1;
        end
      end
    end
    chk_integ_wait: assert property (@(posedge mclk)
      disable iff (srst) rx_signaling_control_q[`TSX_B_INTEG] && chg[c] |->
      cnt_q >= `TSX_INTEG_PREV && smp == cand_q)
      else $error("change reported before three stable multiframes");
    chk_rss_every: assert property (@(posedge mclk) disable iff (srst)
      chg[c] |=> rss_q[c])
      else $error("channel change not recorded in status");
  end

  always_comb begin
    rss_clr = 32'h0;
    if (wr_hit && in_grp(off, `TSX_RSS, `TSX_N4)) begin
      rss_clr[gsel +: 8] = reg_wdata;
    end
  end

  // Set wins over a clear landing in the same cycle
  always_ff @(posedge mclk) begin
    if (srst) begin
      rss_q <= 32'h0;
      rx_latched_status_four_q <= 1'b0;
      interrupt_out_n <= 1'b1;
    end else begin
      rss_q <= (rss_q & ~rss_clr) | chg;
      rx_latched_status_four_q <= (rx_latched_status_four_q && !(wr_hit && in_grp(off, `TSX_RX_LATCHED_STATUS_FOUR, `TSX_N1) &&
                reg_wdata[`TSX_B_COS])) || |(chg & cse_q);
      interrupt_out_n <= !(rx_latched_status_four_q && rx_interrupt_mask_four_q);
    end
  end

  chk_cos_gate: assert property (@(posedge mclk) disable iff (srst)
    $rose(rx_latched_status_four_q) |-> $past(|(chg & cse_q)))
    else $error("change latch set without an enabled channel change");
  chk_int_drive: assert property (@(posedge mclk) disable iff (srst)
    rx_latched_status_four_q && rx_interrupt_mask_four_q |=> !interrupt_out_n)
    else $error("interrupt not driven low on unmasked change");
  chk_rss_sticky: assert property (@(posedge mclk) disable iff (srst)
    rss_q[0] && !rss_clr[0] |=> rss_q[0])
    else $error("status bit dropped without a host clear");
  chk_rx_boundary: assert property (@(posedge mclk) disable iff (srst)
    !mf_ev |=> $stable(rxv_v))
    else $error("receive registers changed off a boundary");
  chk_freeze_hold: assert property (@(posedge mclk) disable iff (srst)
    freeze_q |=> $stable(rxv_v) &&
    rss_q == ($past(rss_q) & ~$past(rss_clr)))
    else $error("receive registers updated during freeze");

  // ---------------- Link side ----------------
  logic lrst_m_q, lrst_q;
  logic [3:0] cfg_m_q, cfg_q;
  logic ack_m_q, ack_s_q, ack_d_q;
  logic [7:0] pos_q, pos_c;
  logic [4:0] frm_q, frm_c, frm_last;
  logic [127:0] hw_buf_v, hw_act_v, tx_val_v, rx_sh_v;
  logic [31:0] tx_sw_q, tx_hw_q, tx_ao_q;
  tsx_pkg::tsx_slot_t sl, ns;
  logic sl_sw, sl_hw, exp_sw, exp_hw, d4, rs_bit;

  always_ff @(posedge tx_backplane_clock) begin
    lrst_m_q <= srst;
    lrst_q <= lrst_m_q;
    cfg_m_q <= {freeze_q, mode_ccs, mode_esf, mode_e1};
    cfg_q <= cfg_m_q;
    ack_m_q <= ack_tog_q;
    ack_s_q <= ack_m_q;
  end

  assign pos_c = mf_sync ? 8'h00 : pos_q;
  assign frm_c = mf_sync ? 5'h00 : frm_q;
  assign frm_last = cfg_q[0] ? `TSX_E1_MF_LAST :
                    cfg_q[1] ? `TSX_ESF_MF_LAST : `TSX_D4_MF_LAST;
  assign d4 = !cfg_q[0] && !cfg_q[1];

  always_ff @(posedge tx_backplane_clock) begin
    if (lrst_q) begin
      pos_q <= 8'h00;
      frm_q <= 5'h00;
    end else if (pos_c == (cfg_q[0] ? `TSX_E1_POS_LAST :
                           `TSX_T1_POS_LAST)) begin
      pos_q <= 8'h00;
      frm_q <= (frm_c == frm_last) ? 5'h00 : frm_c + 5'h01;
    end else begin
      pos_q <= pos_c + 8'h01;
      frm_q <= frm_c;
    end
  end

  assign sl = sig_slot(pos_c, frm_c, cfg_q[0], cfg_q[1], cfg_q[2]);
  assign ns = nib_slot(pos_c, cfg_q[0]);
  assign sl_sw = sl.hit && tx_sw_q[sl.ch];
  assign sl_hw = sl.hit && tx_hw_q[sl.ch];
  assign exp_sw = tx_val_v[{sl.ch, ~sl.sel}];
  assign exp_hw = hw_act_v[{sl.ch, ~sl.sel}];

  // Boundary handling and buffer capture
  always_ff @(posedge tx_backplane_clock) begin
    if (lrst_q) begin
      mf_tog_q <= 1'b0;
      hw_buf_v <= 128'h0;
      hw_act_v <= 128'h0;
      rx_sh_v <= 128'h0;
      rx_done_v <= 128'h0;
    end else begin
      if (ns.hit) begin
        hw_buf_v[{ns.ch, ~ns.sel}] <= tx_signaling_in_pin;
      end
      if (sl.hit) rx_sh_v[{sl.ch, ~sl.sel}] <= rx_data_in;
      if (mf_sync) begin
        mf_tog_q <= ~mf_tog_q;
        hw_act_v <= hw_buf_v;
        if (!cfg_q[3]) rx_done_v <= rx_sh_v;
      end
    end
  end

  // Register snapshot arrives a few cycles after the boundary
  always_ff @(posedge tx_backplane_clock) begin
    if (lrst_q) begin
      ack_d_q <= 1'b0;
      tx_val_v <= 128'h0;
      tx_sw_q <= 32'h0;
      tx_hw_q <= 32'h0;
      tx_ao_q <= 32'h0;
    end else begin
      ack_d_q <= ack_s_q;
      if (ack_s_q ^ ack_d_q) begin
        tx_val_v <= snap_val_q;
        tx_sw_q <= snap_sw_q;
        tx_hw_q <= snap_hw_q;
        tx_ao_q <= snap_ao_q;
      end
    end
  end

  // D4 repeats A and B in the C and D places of the pin nibble
  always_comb begin
    rs_bit = d4 ? rx_done_v[{ns.ch, 1'b1, ~ns.sel[0]}] :
                  rx_done_v[{ns.ch, ~ns.sel}];
    if (tx_ao_q[ns.ch]) rs_bit = 1'b1;
  end

  // Register source has priority when both are selected
  always_ff @(posedge tx_backplane_clock) begin
    if (lrst_q) begin
      tx_data_out <= 1'b0;
      rx_signaling_out_pin <= 1'b0;
    end else begin
      if (sl_sw) tx_data_out <= exp_sw;
      else if (sl_hw) tx_data_out <= exp_hw;
      else tx_data_out <= tx_backplane_data_in;
      rx_signaling_out_pin <= ns.hit && rs_bit;
    end
  end

  chk_sw_insert: assert property (@(posedge tx_backplane_clock)
    disable iff (lrst_q) sl_sw |=> tx_data_out == $past(exp_sw))
    else $error("register signaling not inserted");
  chk_hw_insert: assert property (@(posedge tx_backplane_clock)
    disable iff (lrst_q) !sl_sw && sl_hw |=> tx_data_out == $past(exp_hw))
    else $error("pin signaling not inserted");
  chk_pass_thru: assert property (@(posedge tx_backplane_clock)
    disable iff (lrst_q)
    !sl_sw && !sl_hw |=> tx_data_out == $past(tx_backplane_data_in))
    else $error("unselected bit altered");

endmodule // tsx_signaling

/* bench/tsx_backplane_model.sv */
// Backplane model: framed serial streams and multiframe sync on the link
`timescale 1ns/1ps
module tsx_backplane_model (
  input wire logic lclk,
  input wire logic run,
  input wire logic mode_e1,
  input wire logic mode_esf,
  input wire logic tx_fill,
  input wire logic [3:0] sig_nib,
  input wire logic [3:0] rx_nib,
  output logic mf_sync,
  output logic tx_data,
  output logic sig_data,
  output logic rx_data,
  output logic [12:0] cur_idx
);
  logic [4:0] fr_q;
  logic [7:0] pos_q;
  logic started_q;
  logic [7:0] p;
  logic [7:0] pos_last;
  logic [4:0] fr_last;
  logic [1:0] k;
  logic robbed;
  assign fr_last = mode_e1 ? 5'h0f : (mode_esf ? 5'h17 : 5'h0b);
  assign pos_last = mode_e1 ? 8'hff : 8'hc0;
  // T1 position 0 is the framing bit, channel bytes start one later
  assign p = mode_e1 ? pos_q : pos_q - 8'h01;
  assign k = 2'(fr_q / 5'h06);
  assign robbed = !mode_e1 && pos_q != 8'h00 && p[2:0] == 3'h7 &&
    fr_q % 5'h06 == 5'h05;
  assign cur_idx = {fr_q, pos_q};
  assign mf_sync = started_q && fr_q == 5'h00 && pos_q == 8'h00;
  assign tx_data = started_q && tx_fill;
  // Bits off the signaling slots toggle so stale data never matches
  assign rx_data = started_q && (robbed ? rx_nib[~k] : pos_q[0]);
  assign sig_data = started_q && (!mode_e1 && pos_q != 8'h00 && p[2] ?
    sig_nib[~p[1:0]] : pos_q[1]);
  // Stream moves on the falling edge so the design samples settled bits
  always @(negedge lclk) begin
    if (!run) begin
      started_q <= 1'b0;
      fr_q <= 5'h00;
      pos_q <= 8'h00;
    end else if (!started_q) begin
      started_q <= 1'b1;
    end else if (pos_q == pos_last) begin
      pos_q <= 8'h00;
      fr_q <= (fr_q >= fr_last) ? 5'h00 : fr_q + 5'h01;
    end else begin
      pos_q <= pos_q + 8'h01;
    end
  end
endmodule // tsx_backplane_model

/* bench/tsx_signaling_tb_top.sv */
// Testbench for the signaling block: register port and framed link traffic
`timescale 1ns/1ps
module tsx_signaling_tb_top;
  logic mclk, srst, reg_wr, reg_rd, lclk, run, tx_fill;
  logic [10:0] reg_addr;
  logic [7:0] reg_wdata, reg_rdata_q, rd, held;
  logic interrupt_out_n, freeze_active, mode_e1, mode_esf, mf_sync;
  logic tx_in, sig_in, rx_in, tx_data_out, rx_signaling_out_pin;
  logic [3:0] sig_nib, rx_nib;
  logic loss_in;
  logic [12:0] cur_idx, prev_idx;
  logic cap_tx [0:8191];
  logic cap_rx [0:8191];
  logic [3:0] t1_exp [0:2] = '{4'ha, 4'h6, 4'hf};
  int miscompares, compares;

  tsx_signaling tsx_signaling_inst (
    .mclk(mclk), .srst(srst), .reg_addr(reg_addr), .reg_wr(reg_wr),
    .reg_rd(reg_rd), .reg_wdata(reg_wdata), .reg_rdata_q(reg_rdata_q),
    .interrupt_out_n(interrupt_out_n), .freeze_active(freeze_active),
    .mode_e1(mode_e1), .mode_esf(mode_esf), .mode_ccs(1'b0),
    .rx_loss_sync(loss_in), .rx_carrier_loss(1'b0), .rx_align_change(1'b0),
    .tx_backplane_clock(lclk), .mf_sync(mf_sync),
    .tx_backplane_data_in(tx_in), .tx_signaling_in_pin(sig_in),
    .rx_data_in(rx_in), .tx_data_out(tx_data_out),
    .rx_signaling_out_pin(rx_signaling_out_pin));

  tsx_backplane_model tsx_backplane_model_inst (
    .lclk(lclk), .run(run), .mode_e1(mode_e1), .mode_esf(mode_esf),
    .tx_fill(tx_fill), .sig_nib(sig_nib), .rx_nib(rx_nib),
    .mf_sync(mf_sync), .tx_data(tx_in), .sig_data(sig_in),
    .rx_data(rx_in), .cur_idx(cur_idx));

  initial begin
    mclk = 1'b0;
    forever #2 mclk = ~mclk;
  end
  initial begin
    lclk = 1'b0;
    #3.1;
    forever #7.5 lclk = ~lclk;
  end
  // Outputs lag the input bit by one link cycle
  always @(posedge lclk) begin
    cap_tx[prev_idx] <= tx_data_out;
    cap_rx[prev_idx] <= rx_signaling_out_pin;
    prev_idx <= cur_idx;
  end

  task automatic test_done();
    $display("compares %0d miscompares %0d", compares, miscompares);
    if (miscompares == 0 && compares > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask
  task automatic check(input string nm, input logic [7:0] exp,
    input logic [7:0] got);
    compares++;
    if (got !== exp) begin
      miscompares++;
      $display("wrong value %s expected %h seen %h", nm, exp, got);
    end
  endtask
  task automatic wr(input logic [10:0] a, input logic [7:0] d);
    @(negedge mclk);
    reg_addr = a;
    reg_wdata = d;
    reg_wr = 1'b1;
    @(negedge mclk);
    reg_wr = 1'b0;
  endtask
  task automatic rd_reg(input logic [10:0] a);
    @(negedge mclk);
    reg_addr = a;
    reg_rd = 1'b1;
    @(negedge mclk);
    reg_rd = 1'b0;
    rd = reg_rdata_q;
  endtask
  task automatic rd_chk(input logic [10:0] a, input logic [7:0] exp);
    rd_reg(a);
    check($sformatf("reg %h", a), exp, rd);
  endtask
  // Multiframe event reaches the host side a few cycles after the sync
  task automatic wait_mf(input int n);
    repeat (n) @(posedge mf_sync);
    repeat (40) @(negedge mclk);
  endtask
  function automatic logic [7:0] grab(input bit rx, input int base,
    input int step, input int n);
    logic [7:0] g;
    g = 8'h00;
    for (int i = 0; i < n; i++) begin
      g[n-1-i] = rx ? cap_rx[base+step*i] : cap_tx[base+step*i];
    end
    return g;
  endfunction

  initial begin
    repeat (99000) @(posedge mclk);
    miscompares++;
    test_done();
  end

  initial begin
    srst = 1'b1;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    reg_addr = 11'h000;
    reg_wdata = 8'h00;
    mode_e1 = 1'b0;
    mode_esf = 1'b1;
    run = 1'b0;
    tx_fill = 1'b1;
    sig_nib = 4'h6;
    rx_nib = 4'ha;
    loss_in = 1'b0;
    prev_idx = 13'h0000;
    miscompares = 0;
    compares = 0;
    repeat (20) @(negedge mclk);
    srst = 1'b0;
    rd_chk(11'h118, 8'h00);
    wr(11'h118, 8'h5a);
    wr(11'h318, 8'h33);
    rd_chk(11'h118, 8'h5a);
    rd_chk(11'h318, 8'h00);
    wr(11'h04c, 8'hff);
    rd_chk(11'h04c, 8'h00);
    rd_chk(11'h100, 8'h00);
    wr(11'h140, 8'ha0);
    wr(11'h118, 8'h01);
    wr(11'h1c8, 8'h02);
    wr(11'h038, 8'h02);
    repeat (3) @(negedge lclk);
    run = 1'b1;
    repeat (3) @(posedge mf_sync);
    mode_esf = 1'b0;
    rx_nib = 4'h5;
    repeat (40) @(negedge mclk);
    for (int c = 0; c < 3; c++) begin
      check("t1 robbed", {4'h0, t1_exp[c]},
            grab(0, 1288+8*c, 1536, 4));
    end
    check("rx pin", 8'h0a, grab(1, 773, 1, 4));
    check("all ones", 8'h0f, grab(1, 781, 1, 4));
    rd_chk(11'h040, 8'haa);
    rd_chk(11'h098, 8'hff);
    rd_chk(11'h09b, 8'h00);
    rd_chk(11'h093, 8'h00);
    check("irq", 8'h01, {7'h00, interrupt_out_n});
    wr(11'h098, 8'hff);
    rd_chk(11'h098, 8'h00);
    wr(11'h0a8, 8'h01);
    wr(11'h0a3, 8'h08);
    wait_mf(1);
    // Superframe carries only A and B of channel 0
    check("d4 robbed", 8'h02, grab(0, 1288, 1536, 2));
    rd_chk(11'h098, 8'hff);
    rd_chk(11'h093, 8'h08);
    check("irq", 8'h00, {7'h00, interrupt_out_n});
    wr(11'h093, 8'h08);
    rd_chk(11'h093, 8'h00);
    check("irq", 8'h01, {7'h00, interrupt_out_n});
    wr(11'h013, 8'h01);
    rx_nib = 4'ha;
    wait_mf(2);
    rd_chk(11'h093, 8'h00);
    wait_mf(1);
    rd_chk(11'h093, 8'h08);
    wr(11'h013, 8'h02);
    loss_in = 1'b1;
    repeat (8) @(negedge mclk);
    check("freeze en", 8'h01, {7'h00, freeze_active});
    loss_in = 1'b0;
    wr(11'h013, 8'h04);
    repeat (4) @(negedge mclk);
    check("freeze", 8'h01, {7'h00, freeze_active});
    rd_reg(11'h040);
    held = rd;
    rx_nib = 4'h5;
    wr(11'h141, 8'h9c);
    wr(11'h118, 8'h02);
    wr(11'h11a, 8'h02);
    wr(11'h1c8, 8'h00);
    @(posedge mf_sync);
    mode_e1 = 1'b1;
    repeat (40) @(negedge mclk);
    rd_chk(11'h040, held);
    wr(11'h013, 8'h00);
    wait_mf(1);
    check("e1 frame 1", 8'h9c, grab(0, 384, 1, 8));
    check("e1 frame 2", 8'hff, grab(0, 640, 1, 8));
    test_done();
  end
endmodule // tsx_signaling_tb_top
